// [design/dmh_host_port.sv]
// host and dma port with multi-sector sequencing of the disk controller
`timescale 1ns/10ps
`include "dmh_map.svh"
module dmh_host_port (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // processor register port
  input wire logic deviceSelectN,
  input wire logic ioMemSelect,
  input wire logic transferDirection,
  input wire logic registerPortSelect,
  // shared data lines
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  // dma handshake
  output logic dmaRequestN,
  input wire logic dmaAcknowledgeN,
  input wire logic dmaStopN,
  // external select strobes and busy
  output logic headSelectLoadStrobe,
  output logic driveSelectLoadStrobe,
  output logic busy,
  // disk serializer side
  input wire dmh_pkg::dmh_disk_s disk,
  output logic [7:0] diskWriteByte,
  output logic diskWriteValid
);
  dmh_pkg::dmh_state_e state_r, state_nxt;       // sequencer state
  logic isWrite_r, isWrite_nxt;                  // operation direction
  logic [7:0] pointer_r, pointer_nxt;            // register address pointer
  logic [7:0] sector_r, sector_nxt;              // current sector number
  logic [7:0] count_r, count_nxt;                // remaining sectors
  logic [7:0] buf_r, buf_nxt;                    // one-byte transfer holder
  logic bufFull_r, bufFull_nxt;                  // holder occupied
  logic [7:0] lastByte_r, lastByte_nxt;          // last byte taken from dma
  logic stopSeen_r, stopSeen_nxt;                // dma stop seen
  dmh_pkg::dmh_status_s status_r, status_nxt;    // sticky flags
  logic [7:0] dataOut_r, dataOut_nxt;            // data line value
  logic dataOe_r, dataOe_nxt;                    // data line drive
  logic headStb_r, headStb_nxt;                  // head load pulse
  logic driveStb_r, driveStb_nxt;                // drive load pulse
  logic [7:0] wrByte_r, wrByte_nxt;              // byte to the writer
  logic wrValid_r, wrValid_nxt;                  // writer byte pulse
  logic hostWr, hostRd, dmaAck, active;          // decoded strobes
  logic [7:0] statusByte;                        // status as a byte

  // decode processor cycles
  assign hostWr = !deviceSelectN && ioMemSelect && transferDirection;
  assign hostRd = !deviceSelectN && ioMemSelect && !transferDirection;
  assign active = (state_r == dmh_pkg::DMH_XFER);
  assign dmaAck = active && !dmaAcknowledgeN;
  assign statusByte = {4'h0, status_r.trackEnd, status_r.error, status_r.overrun, active};

  // outputs straight from flops
  assign hostDataOut = dataOut_r;
  assign hostDataOe = dataOe_r;
  assign headSelectLoadStrobe = headStb_r;
  assign driveSelectLoadStrobe = driveStb_r;
  assign busy = active;
  assign diskWriteByte = wrByte_r;
  assign diskWriteValid = wrValid_r;
  // request while the holder needs service and no stop was seen
  assign dmaRequestN = !(active && !stopSeen_r && dmaAcknowledgeN &&
                         (isWrite_r ? !bufFull_r : bufFull_r));

  // next-state computation
  always_comb begin
    state_nxt = state_r;
    isWrite_nxt = isWrite_r;
    pointer_nxt = pointer_r;
    sector_nxt = sector_r;
    count_nxt = count_r;
    buf_nxt = buf_r;
    bufFull_nxt = bufFull_r;
    lastByte_nxt = lastByte_r;
    stopSeen_nxt = stopSeen_r;
    status_nxt = status_r;
    dataOut_nxt = dataOut_r;
    dataOe_nxt = 1'b0;
    headStb_nxt = 1'b0;
    driveStb_nxt = 1'b0;
    wrByte_nxt = wrByte_r;
    wrValid_nxt = 1'b0;
    // processor writes: pointer or addressed register
    if (hostWr && !registerPortSelect) begin
      pointer_nxt = hostDataIn;
    end else if (hostWr) begin
      unique case (pointer_r)
        `DMH_HEAD_LOAD_ADDR: headStb_nxt = 1'b1;
        `DMH_DRIVE_LOAD_ADDR: driveStb_nxt = 1'b1;
        `DMH_SECTOR_ADDR: sector_nxt = hostDataIn;
        `DMH_COUNT_ADDR: count_nxt = hostDataIn;
        `DMH_COMMAND_ADDR: begin
          // start only from idle; write wins if both bits set
          if (!active && (hostDataIn[`DMH_CMD_READ_BIT] || hostDataIn[`DMH_CMD_WRITE_BIT])) begin
            state_nxt = dmh_pkg::DMH_XFER;
            isWrite_nxt = hostDataIn[`DMH_CMD_WRITE_BIT];
            bufFull_nxt = 1'b0;
            stopSeen_nxt = 1'b0;
            status_nxt = '0;
          end
        end
        default: begin
        end
      endcase
    end
    // processor reads: status or addressed register
    if (hostRd) begin
      dataOe_nxt = 1'b1;
      if (!registerPortSelect) begin
        dataOut_nxt = statusByte;
      end else begin
        unique case (pointer_r)
          `DMH_STATUS_ADDR: dataOut_nxt = statusByte;
          `DMH_SECTOR_ADDR: dataOut_nxt = sector_r;
          `DMH_COUNT_ADDR: dataOut_nxt = count_r;
          default: dataOut_nxt = `DMH_RESET_BYTE;
        endcase
      end
    end
    // dma byte under acknowledge
    if (dmaAck) begin
      if (!dmaStopN) begin
        stopSeen_nxt = 1'b1;
      end
      if (!isWrite_r && bufFull_r) begin
        dataOut_nxt = buf_r;
        dataOe_nxt = 1'b1;
        bufFull_nxt = 1'b0;
      end else if (isWrite_r && !bufFull_r) begin
        buf_nxt = hostDataIn;
        lastByte_nxt = hostDataIn;
        bufFull_nxt = 1'b1;
      end
    end
    // disk side traffic
    if (active) begin
      // read: only data bytes enter the holder
      if (!isWrite_r && disk.byteValid && disk.byteKind == `DMH_KIND_DATA && !stopSeen_nxt) begin
        if (bufFull_nxt) begin
          status_nxt.overrun = 1'b1;
        end else begin
          buf_nxt = disk.byteData;
          bufFull_nxt = 1'b1;
        end
      end
      // write: feed holder byte, or pad with the last byte
      if (isWrite_r && disk.wantByte) begin
        wrValid_nxt = 1'b1;
        wrByte_nxt = bufFull_nxt ? buf_nxt : lastByte_nxt;
        if (bufFull_nxt) begin
          bufFull_nxt = 1'b0;
        end else if (!stopSeen_nxt) begin
          status_nxt.overrun = 1'b1;
        end
      end
      if (disk.checkFail) begin
        status_nxt.error = 1'b1;
      end
      // sector boundary: advance and test for the end
      if (disk.sectorDone) begin
        sector_nxt = sector_r + 8'h01;
        count_nxt = count_r - 8'h01;
        if (disk.lastSector) begin
          status_nxt.trackEnd = 1'b1;
        end
        if (count_r == 8'h01 || disk.lastSector || status_nxt.error ||
            status_nxt.overrun || stopSeen_nxt) begin
          state_nxt = dmh_pkg::DMH_IDLE;
          bufFull_nxt = 1'b0;
        end
      end
    end
  end

  // registers; reset aborts any operation
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= dmh_pkg::DMH_IDLE;
      isWrite_r <= 1'b0;
      pointer_r <= `DMH_RESET_BYTE;
      sector_r <= `DMH_RESET_BYTE;
      count_r <= `DMH_RESET_BYTE;
      buf_r <= `DMH_RESET_BYTE;
      bufFull_r <= 1'b0;
      lastByte_r <= `DMH_RESET_BYTE;
      stopSeen_r <= 1'b0;
      status_r <= '0;
      dataOut_r <= `DMH_RESET_BYTE;
      dataOe_r <= 1'b0;
      headStb_r <= 1'b0;
      driveStb_r <= 1'b0;
      wrByte_r <= `DMH_RESET_BYTE;
      wrValid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      isWrite_r <= isWrite_nxt;
      pointer_r <= pointer_nxt;
      sector_r <= sector_nxt;
      count_r <= count_nxt;
      buf_r <= buf_nxt;
      bufFull_r <= bufFull_nxt;
      lastByte_r <= lastByte_nxt;
      stopSeen_r <= stopSeen_nxt;
      status_r <= status_nxt;
      dataOut_r <= dataOut_nxt;
      dataOe_r <= dataOe_nxt;
      headStb_r <= headStb_nxt;
      driveStb_r <= driveStb_nxt;
      wrByte_r <= wrByte_nxt;
      wrValid_r <= wrValid_nxt;
    end
  end

  // checks on the sequencing and strobes
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  head_strobe_a: assert property (headSelectLoadStrobe == $past(hostWr && registerPortSelect &&
      pointer_r == `DMH_HEAD_LOAD_ADDR)) else $error("head strobe not tied to a 3D write");
  drive_strobe_a: assert property (hostWr && registerPortSelect && pointer_r == `DMH_DRIVE_LOAD_ADDR
      |=> driveSelectLoadStrobe) else $error("drive strobe missing after 3E write");
  sector_advance_a: assert property (active && disk.sectorDone && !hostWr
      |=> sector_r == $past(sector_r) + 8'h01) else $error("sector number did not advance");
  count_decrement_a: assert property (active && disk.sectorDone && !hostWr
      |=> count_r == $past(count_r) - 8'h01) else $error("sector count did not decrement");
  last_count_end_a: assert property (active && disk.sectorDone && count_r == 8'h01
      |=> !busy) else $error("busy stayed high after final sector");
  stop_no_request_a: assert property (stopSeen_r |-> dmaRequestN) else $error("request after stop");
  read_overrun_a: assert property (active && !isWrite_r && bufFull_r && dmaAcknowledgeN && !stopSeen_r &&
      disk.byteValid && disk.byteKind == `DMH_KIND_DATA |=> status_r.overrun) else $error("overrun not flagged");
  write_pad_a: assert property (active && isWrite_r && disk.wantByte && !bufFull_r && dmaAcknowledgeN
      |=> diskWriteValid && diskWriteByte == $past(lastByte_r)) else $error("write not padded with last byte");
  drive_cause_a: assert property (hostDataOe |-> $past(hostRd || dmaAck)) else $error("data lines driven unasked");
  busy_hold_a: assert property (busy && !disk.sectorDone |=> busy) else $error("busy fell mid sector");
endmodule

// [pkg/dmh_map.svh]
// register offsets, field positions and status layout for the disk host port
`ifndef DMH_MAP_SVH
`define DMH_MAP_SVH
// addressed registers behind the pointer
`define DMH_HEAD_LOAD_ADDR 8'h3D
`define DMH_DRIVE_LOAD_ADDR 8'h3E
`define DMH_STATUS_ADDR 8'h05
`define DMH_SECTOR_ADDR 8'h31
`define DMH_COUNT_ADDR 8'h32
`define DMH_COMMAND_ADDR 8'h30
// command bits
`define DMH_CMD_READ_BIT 0
`define DMH_CMD_WRITE_BIT 1
// status bits
`define DMH_ST_BUSY_BIT 0
`define DMH_ST_OVERRUN_BIT 1
`define DMH_ST_ERROR_BIT 2
`define DMH_ST_TRACKEND_BIT 3
// reset values
`define DMH_RESET_BYTE 8'h00
// byte kinds from the disk reader
`define DMH_KIND_DATA 2'h0
`endif

// [pkg/dmh_pkg.sv]
// types shared by the disk host port
package dmh_pkg;
  // sequencer states
  typedef enum logic [0:0] {
    DMH_IDLE = 1'b0,
    DMH_XFER = 1'b1
  } dmh_state_e;
  // events from the disk serializer side
  typedef struct packed {
    logic byteValid;      // a byte came off the disk
    logic [1:0] byteKind; // data, identifier or check byte
    logic [7:0] byteData; // the byte itself
    logic wantByte;       // writer needs the next byte
    logic sectorDone;     // current sector finished
    logic lastSector;     // that sector was the last of the track
    logic checkFail;      // identifier or check mismatch
  } dmh_disk_s;
  // sticky status flags
  typedef struct packed {
    logic trackEnd;
    logic error;
    logic overrun;
  } dmh_status_s;
endpackage

// [testbench/dmh_dma_model.sv]
// dma buffer side model for the disk host port
`timescale 1ns/10ps
module dmh_dma_model (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // dma handshake and data lines
  input wire logic dmaRequestN,
  output logic dmaAcknowledgeN,
  output logic dmaStopN,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe,
  output logic [7:0] ramData,
  // bench controls and results
  input wire logic hold,
  input wire logic [7:0] stopAt,
  output logic [7:0] nAck,
  output logic [7:0] lastRd
);
  logic ackSeen; // a byte was acknowledged last cycle
  // ram byte offered while acknowledged
  assign ramData = 8'hA0 + nAck;
  // one full-cycle acknowledge per request, hold stalls
  always @(negedge mclk or negedge nrst) begin
    if (!nrst) begin
      dmaAcknowledgeN <= 1'b1;
      dmaStopN <= 1'b1;
      nAck <= 8'h00;
    end else if (!dmaAcknowledgeN || dmaRequestN || hold) begin
      dmaAcknowledgeN <= 1'b1;
      dmaStopN <= 1'b1;
    end else begin
      dmaAcknowledgeN <= 1'b0;
      dmaStopN <= (nAck == stopAt) ? 1'b0 : 1'b1; // stop only with acknowledge
      nAck <= nAck + 8'h01;
    end
  end
  // keep the byte driven after an acknowledge
  always @(posedge mclk) begin
    ackSeen <= !dmaAcknowledgeN;
    if (ackSeen && hostDataOe)
      lastRd <= hostDataOut;
  end
endmodule

// [testbench/dmh_host_port_tb.sv]
// self-checking bench for the disk host port
`timescale 1ns/10ps
`include "dmh_map.svh"
module dmh_host_port_tb;
  logic mclk, nrst, selN, ioSel, dir, a0, hold, ackN, stopN, oe, reqN, hStb, dStb, busy, wv, busyQ;
  logic [7:0] cpuData, ramData, dOut, stopAt, nAck, lastRd, wb, got, v, n0, hc, dc, falls;
  dmh_pkg::dmh_disk_s disk; // disk side events
  int mismatches, comparisons;
  // device, lines carry ram data while acknowledged
  dmh_host_port i_dut (.mclk(mclk), .nrst(nrst), .deviceSelectN(selN), .ioMemSelect(ioSel),
    .transferDirection(dir), .registerPortSelect(a0), .hostDataIn(ackN ? cpuData : ramData),
    .hostDataOut(dOut), .hostDataOe(oe), .dmaRequestN(reqN), .dmaAcknowledgeN(ackN),
    .dmaStopN(stopN), .headSelectLoadStrobe(hStb), .driveSelectLoadStrobe(dStb), .busy(busy),
    .disk(disk), .diskWriteByte(wb), .diskWriteValid(wv));
  // dma buffer side
  dmh_dma_model i_dma (.mclk(mclk), .nrst(nrst), .dmaRequestN(reqN), .dmaAcknowledgeN(ackN),
    .dmaStopN(stopN), .hostDataOut(dOut), .hostDataOe(oe), .ramData(ramData), .hold(hold),
    .stopAt(stopAt), .nAck(nAck), .lastRd(lastRd));
  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // strobe pulse counters
  always @(negedge mclk) begin
    hc <= hc + {7'h00, hStb};
    dc <= dc + {7'h00, dStb};
    // host interrupt source: falling edges of busy
    busyQ <= busy;
    falls <= falls + {7'h00, busyQ && !busy};
  end
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // compare one byte result
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one io cycle, select held over one edge
  task automatic io(input logic wr, input logic port, input logic [7:0] d);
    int n;
    {selN, ioSel, dir, a0, cpuData} = {1'b0, 1'b1, wr, port, d};
    @(negedge mclk);
    selN = 1'b1;
    cpuData = ~d; // released lines show the inverse, so a late sample is caught
    for (n = 0; !wr && n < 4 && oe !== 1'b1; n++)
      @(negedge mclk);
    if (n == 4) begin
      mismatches++;
      finish_test();
    end
    v = dOut;
    @(negedge mclk);
  endtask
  task automatic setReg(input logic [7:0] a, input logic [7:0] d);
    io(1'b1, 1'b0, a);
    io(1'b1, 1'b1, d);
  endtask
  task automatic getReg(input logic [7:0] a);
    io(1'b1, 1'b0, a);
    io(1'b0, 1'b1, 8'h00);
  endtask
  // program sector, count and command
  task automatic start(input logic [7:0] sec, input logic [7:0] cnt, input logic [7:0] cmd);
    setReg(`DMH_SECTOR_ADDR, sec);
    setReg(`DMH_COUNT_ADDR, cnt);
    setReg(`DMH_COMMAND_ADDR, cmd);
    repeat (4) @(negedge mclk);
  endtask
  // one disk event, then catch any written byte
  task automatic ev(input logic [14:0] e);
    disk = e;
    got = 8'hXX;
    @(negedge mclk);
    disk = '0;
    repeat (8) begin
      if (wv === 1'b1)
        got = wb;
      @(negedge mclk);
    end
  endtask
  // two sectors read, id bytes stay inside
  task automatic t_read();
    n0 = nAck;
    start(8'h05, 8'h02, 8'h01);
    io(1'b0, 1'b0, 8'h00);
    chk("status busy", 8'h01, v & 8'h01);
    for (int s = 0; s < 2; s++) begin
      ev({3'b100, 8'h30 + s[7:0], 4'h0});
      chk("dma byte", 8'h30 + s[7:0], lastRd);
      ev({3'b101, 8'hFF, 4'h0});
      chk("busy mid", 8'h01, {7'h00, busy});
      ev({11'h000, 4'h4});
    end
    chk("bytes moved", 8'h02, nAck - n0);
    chk("busy end", 8'h00, {7'h00, busy});
    chk("busy falls", 8'h01, falls);
    getReg(`DMH_SECTOR_ADDR);
    chk("sector", 8'h07, v);
    getReg(`DMH_COUNT_ADDR);
    chk("count", 8'h00, v);
  endtask
  // write ended by the last sector of the track
  task automatic t_write();
    start(8'h09, 8'h03, 8'h02);
    repeat (2) begin
      n0 = nAck;
      ev({11'h000, 4'h8});
      chk("write byte", 8'hA0 + n0, got);
    end
    ev({11'h000, 4'h4});
    chk("busy next", 8'h01, {7'h00, busy});
    ev({11'h000, 4'h6});
    chk("busy track end", 8'h00, {7'h00, busy});
  endtask
  // stop on first byte, sector padded
  task automatic t_stop();
    stopAt = nAck;
    start(8'h00, 8'h02, 8'h02);
    n0 = nAck;
    repeat (2) begin
      ev({11'h000, 4'h8});
      chk("pad byte", 8'hA1 + stopAt, got);
    end
    chk("no request", n0, nAck);
    ev({11'h000, 4'h4});
    chk("busy stop", 8'h00, {7'h00, busy});
    stopAt = 8'hFF;
  endtask
  // read overrun and check failure, first byte kept and drained later
  task automatic t_rderr();
    hold = 1'b1;
    start(8'h10, 8'h03, 8'h01);
    ev({3'b100, 8'h11, 4'h0});
    ev({3'b100, 8'h22, 4'h0});
    ev({11'h000, 4'h1});
    io(1'b0, 1'b0, 8'h00);
    chk("read faults", 8'h06, v & 8'h06);
    hold = 1'b0;
    repeat (2) @(negedge mclk);
    ev({11'h000, 4'h4});
    chk("busy error", 8'h00, {7'h00, busy});
    chk("kept byte", 8'h11, lastRd);
  endtask
  // starved writer, then reset in mid read
  task automatic t_fault();
    hold = 1'b1;
    start(8'h00, 8'h02, 8'h02);
    ev({11'h000, 4'h8});
    io(1'b0, 1'b0, 8'h00);
    chk("overrun bit", 8'h02, v & 8'h02);
    ev({11'h000, 4'h4});
    chk("busy overrun", 8'h00, {7'h00, busy});
    start(8'h01, 8'h04, 8'h01);
    ev({3'b100, 8'h55, 4'h0});
    nrst = 1'b0;
    @(negedge mclk);
    chk("busy reset", 8'h00, {7'h00, busy});
    chk("request reset", 8'h01, {7'h00, reqN});
    nrst = 1'b1;
    hold = 1'b0;
    getReg(`DMH_SECTOR_ADDR);
    chk("sector reset", 8'h00, v);
  endtask
  initial begin
    nrst = 1'b0;
    {selN, ioSel, dir, a0, hold, busyQ, cpuData, stopAt, hc, dc, falls} = {6'b100000, 8'h00, 8'hFF, 24'h000000};
    disk = '0;
    repeat (6) @(negedge mclk);
    chk("busy at reset", 8'h00, {7'h00, busy});
    nrst = 1'b1;
    setReg(`DMH_HEAD_LOAD_ADDR, 8'h3C);
    repeat (4) @(negedge mclk);
    chk("head pulses", 8'h01, hc);
    setReg(`DMH_DRIVE_LOAD_ADDR, 8'h3C);
    repeat (4) @(negedge mclk);
    chk("drive pulses", 8'h01, dc);
    t_read();
    t_write();
    t_stop();
    t_rderr();
    t_fault();
    finish_test();
  end
endmodule
